// file: rtl/timer16_pkg.sv
// package of register map, field layouts and reset values for the timer
// assumes a word-addressed avalon-mm slave; byte address = 4 * index
//
// How it works
// - enable bit starts, stops, reads running
// - transmit: modulo reloads, single pass stops
// - demod: select bit chooses edge response
// - ignore set: edges skipped, no reload
// - ignore set: narrow timeout captures, interrupts
// - writing 0 then 1 arms one edge
// - demod zero wraps to FFFFh, flags timeout
// - timeout flag reads set, write one clears
// - capture mask gates capture interrupt
// - timeout mask gates timeout interrupt, resets 0
// - bit 0 routes counter output to pin
// - ping-pong only in transmit, select bits
// - start loads level-chosen narrow reload value
// - narrow terminal hands over to wide counter
// - wide terminal hands back, repeats forever
// - select bits 00 end ping-pong
package timer16_pkg;

	// ==================================================================
	// register indices (word addresses)
	localparam logic [3:0] IDX_PORT_CFG   = 4'h0;
	localparam logic [3:0] IDX_SHARED     = 4'h1;
	localparam logic [3:0] IDX_WIDE_CTL   = 4'h2;
	localparam logic [3:0] IDX_NARROW_CTL = 4'h3;
	localparam logic [3:0] IDX_WIDE_RH    = 4'h4;
	localparam logic [3:0] IDX_WIDE_RL    = 4'h5;
	localparam logic [3:0] IDX_NARROW_RH  = 4'h6;
	localparam logic [3:0] IDX_NARROW_RL  = 4'h7;
	localparam logic [3:0] IDX_CAPT_H     = 4'h8;
	localparam logic [3:0] IDX_CAPT_L     = 4'h9;
	localparam logic [3:0] IDX_IRQ_STAT   = 4'hA;
	localparam logic [3:0] IDX_IRQ_CLR    = 4'hB;
	localparam logic [3:0] IDX_IRQ_EN     = 4'hC;

	// ==================================================================
	// field positions
	localparam int BIT_ENABLE  = 7;
	localparam int BIT_SINGLE  = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int IRQ_WIDE    = 0;
	localparam int IRQ_CAPT    = 1;
	localparam int IRQ_NARROW  = 2;

	// edge select encodings; other codes mean both edges
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// clock field encodings
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;

	// ==================================================================
	// reset values
	localparam logic [7:0] CTL_RST    = 8'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [2:0] IRQ_RST    = 3'h0;

	// wide counter control layout (writable part)
	typedef struct packed {
		logic       enable;
		logic       single;
		logic       timeout;
		logic [1:0] clk_div;
		logic       capt_mask;
		logic       tout_mask;
		logic       pin_sel;
	} wide_ctl_t;

	// shared control layout
	typedef struct packed {
		logic       rsv;
		logic       demod;
		logic [1:0] edge_sel;
		logic [1:0] pp_sel;
		logic       narrow_init;
		logic       wide_init;
	} shared_ctl_t;

endpackage

// file: rtl/timer16_demod_pingpong.sv
// timer block: sixteen-bit down-counter, eight-bit partner, registers
// assumes carrier_in synchronous to clk_in; one wait state per access
`timescale 1ns/1ps
module timer16_demod_pingpong (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        carrier_in,
	input  wire logic        port_data_in,
	output logic             wide_timer_output_pin_out,
	output logic             narrow_counter_output_out,
	output logic             irq_out
);
	import timer16_pkg::*;

	// ==================================================================
	// bus slave
	logic        ack_q;       // high in the answering cycle
	logic        wr;          // write takes effect this edge
	logic [7:0]  wdat;        // low byte of write data
	logic [31:0] rdat_q;      // read data register

	timer16_pkg::wide_ctl_t   wctl_q;    // wide static fields
	timer16_pkg::shared_ctl_t shr_q;     // shared control
	logic [7:0]  port_cfg_q;  // write-only port config
	logic        nsingle_q;   // narrow single pass
	logic        nmask_q;     // narrow timeout mask
	logic [7:0]  wrh_q;       // wide reload high
	logic [7:0]  wrl_q;       // wide reload low
	logic [7:0]  nrh_q;       // narrow reload high
	logic [7:0]  nrl_q;       // narrow reload low
	logic [2:0]  stat_q;      // sticky irq status
	logic [2:0]  irq_en_q;    // irq enables

	// true when this edge writes register idx
	function automatic logic wr_to(input logic [3:0] idx);
		wr_to = wr && (avs_address_in == idx);
	endfunction

	assign wr   = avs_write_in & ack_q & avs_byteenable_in[0];
	assign wdat = avs_writedata_in[7:0];
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_readdata_out    = rdat_q;

	// ack toggles high for one cycle after a request arrives
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
		end
	end

	// ==================================================================
	// counter state
	logic [15:0] wcnt_q;      // wide counter
	logic        wen_q;       // wide running
	logic        wout_q;      // wide output level
	logic        wtout_q;     // wide timeout flag
	logic [15:0] capt_q;      // captured value
	logic [7:0]  ncnt_q;      // narrow counter
	logic        nen_q;       // narrow running
	logic        nout_q;      // narrow output level
	logic        ntout_q;     // narrow timeout flag
	logic        arm_q;       // one edge armed
	logic        carr_q;      // previous carrier level
	logic [2:0]  pre_q;       // prescaler
	logic        pin_q;       // pin driver

	// read mux, sampled in the waiting cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdat_q <= 32'h0000_0000;
		end else if (avs_read_in & ~ack_q) begin
			case (avs_address_in)
				IDX_SHARED:     rdat_q <= {24'h0, shr_q};
				IDX_WIDE_CTL:   rdat_q <= {24'h0, wen_q,
					wctl_q.single, wtout_q, wctl_q[4:0]};
				IDX_NARROW_CTL: rdat_q <= {24'h0, nen_q, nsingle_q,
					ntout_q, 3'h0, nmask_q, 1'b0};
				IDX_WIDE_RH:    rdat_q <= {24'h0, wrh_q};
				IDX_WIDE_RL:    rdat_q <= {24'h0, wrl_q};
				IDX_NARROW_RH:  rdat_q <= {24'h0, nrh_q};
				IDX_NARROW_RL:  rdat_q <= {24'h0, nrl_q};
				IDX_CAPT_H:     rdat_q <= {24'h0, capt_q[15:8]};
				IDX_CAPT_L:     rdat_q <= {24'h0, capt_q[7:0]};
				IDX_IRQ_STAT:   rdat_q <= {29'h0, stat_q};
				IDX_IRQ_EN:     rdat_q <= {29'h0, irq_en_q};
				default:        rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	// software-written configuration
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wctl_q     <= CTL_RST;
			shr_q      <= CTL_RST;
			port_cfg_q <= CTL_RST;
			nsingle_q  <= 1'b0;
			nmask_q    <= 1'b0;
			wrh_q      <= RELOAD_RST;
			wrl_q      <= RELOAD_RST;
			nrh_q      <= RELOAD_RST;
			nrl_q      <= RELOAD_RST;
			irq_en_q   <= IRQ_RST;
		end else begin
			if (wr_to(IDX_WIDE_CTL))   wctl_q     <= wdat;
			if (wr_to(IDX_SHARED))     shr_q      <= wdat;
			if (wr_to(IDX_PORT_CFG))   port_cfg_q <= wdat;
			if (wr_to(IDX_WIDE_RH))    wrh_q      <= wdat;
			if (wr_to(IDX_WIDE_RL))    wrl_q      <= wdat;
			if (wr_to(IDX_NARROW_RH))  nrh_q      <= wdat;
			if (wr_to(IDX_NARROW_RL))  nrl_q      <= wdat;
			if (wr_to(IDX_IRQ_EN))     irq_en_q   <= wdat[2:0];
			if (wr_to(IDX_NARROW_CTL)) begin
				nsingle_q <= wdat[BIT_SINGLE];
				nmask_q   <= wdat[1];
			end
		end
	end

	// ==================================================================
	// derived controls
	logic        pp;          // ping-pong active
	logic        demod;       // demodulation mode
	logic        wtick;       // prescaled wide tick
	logic        wtc;         // wide terminal count
	logic        ntc;         // narrow terminal count
	logic        rise;        // carrier rising
	logic        fall;        // carrier falling
	logic        qual;        // qualifying edge
	logic        ehit;        // edge acted on
	logic        ncapt;       // narrow-timeout capture
	logic        capt_ev;     // any capture
	logic [15:0] wreload;     // wide reload value

	// narrow reload chosen by output level
	function automatic logic [7:0] nreload(input logic lvl);
		nreload = lvl ? nrh_q : nrl_q;
	endfunction

	assign demod   = shr_q.demod;
	assign pp      = (shr_q.pp_sel != 2'h0) & ~demod;
	assign wreload = {wrh_q, wrl_q};
	assign rise    = carrier_in & ~carr_q;
	assign fall    = ~carrier_in & carr_q;
	assign qual    = (shr_q.edge_sel == EDGE_RISE) ? rise :
	                 (shr_q.edge_sel == EDGE_FALL) ? fall : (rise | fall);
	assign ehit    = demod & wen_q & qual
	               & (~wctl_q.single | arm_q);
	assign ntc     = nen_q & (ncnt_q == 8'h00);
	assign ncapt   = demod & wen_q & wctl_q.single & ntc;
	assign capt_ev = ehit | ncapt;
	assign wtc     = wen_q & wtick & (wcnt_q == 16'h0000);

	// prescaler tick for the wide counter
	always_comb begin
		case (wctl_q.clk_div)
			DIV_1:   wtick = 1'b1;
			DIV_2:   wtick = pre_q[0];
			DIV_4:   wtick = &pre_q[1:0];
			default: wtick = &pre_q;
		endcase
	end

	// free-running prescaler and carrier history
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_q  <= 3'h0;
			carr_q <= 1'b0;
		end else begin
			pre_q  <= pre_q + 3'h1;
			carr_q <= carrier_in;
		end
	end

	// ==================================================================
	// wide counter, its enable and output level
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wcnt_q <= 16'h0000;
			wen_q  <= 1'b0;
			wout_q <= 1'b0;
		end else if (wr_to(IDX_WIDE_CTL)) begin
			wen_q <= wdat[BIT_ENABLE];
			if (wdat[BIT_ENABLE] & ~wen_q) begin
				wcnt_q <= wreload;
				if (pp) wout_q <= shr_q.wide_init;
			end
		end else if (pp & ntc) begin
			wen_q  <= 1'b1;
			wout_q <= shr_q.wide_init;
			wcnt_q <= wreload;
		end else if (ehit) begin
			wcnt_q <= wreload;
		end else if (wen_q & wtick) begin
			if (demod | (wcnt_q != 16'h0000)) begin
				wcnt_q <= wcnt_q - 16'h0001;
			end else begin
				wout_q <= ~wout_q;
				if (wctl_q.single | pp) wen_q <= 1'b0;
				else wcnt_q <= wreload;
			end
		end
	end

	// edge arming by a 0-then-1 write of the select bit
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			arm_q <= 1'b0;
		end else if (wr_to(IDX_WIDE_CTL)) begin
			arm_q <= wdat[BIT_SINGLE] & ~wctl_q.single;
		end else if (ehit) begin
			arm_q <= 1'b0;
		end
	end

	// capture register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			capt_q <= 16'h0000;
		end else if (capt_ev) begin
			capt_q <= wcnt_q;
		end
	end

	// ==================================================================
	// narrow counter, counting every clock
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ncnt_q <= 8'h00;
			nen_q  <= 1'b0;
			nout_q <= 1'b0;
		end else if (wr_to(IDX_NARROW_CTL)) begin
			nen_q <= wdat[BIT_ENABLE];
			if (wdat[BIT_ENABLE] & ~nen_q) begin
				nout_q <= shr_q.narrow_init;
				ncnt_q <= nreload(shr_q.narrow_init);
			end
		end else if (pp & wtc) begin
			nen_q  <= 1'b1;
			nout_q <= shr_q.narrow_init;
			ncnt_q <= nreload(shr_q.narrow_init);
		end else if (nen_q) begin
			if (ncnt_q != 8'h00) begin
				ncnt_q <= ncnt_q - 8'h01;
			end else begin
				nout_q <= ~nout_q;
				ncnt_q <= nreload(~nout_q);
				if (nsingle_q | pp) nen_q <= 1'b0;
			end
		end
	end

	// ==================================================================
	// timeout flags: a set in the clearing cycle wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wtout_q <= 1'b0;
			ntout_q <= 1'b0;
		end else begin
			if (wtc) wtout_q <= 1'b1;
			else if (wr_to(IDX_WIDE_CTL) & wdat[BIT_TIMEOUT])
				wtout_q <= 1'b0;
			if (ntc) ntout_q <= 1'b1;
			else if (wr_to(IDX_NARROW_CTL) & wdat[BIT_TIMEOUT])
				ntout_q <= 1'b0;
		end
	end

	// sticky interrupt status, masked at the source
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat_q <= IRQ_RST;
		end else begin
			if (wtc & wctl_q.tout_mask)
				stat_q[IRQ_WIDE] <= 1'b1;
			else if (wr_to(IDX_IRQ_CLR) & wdat[IRQ_WIDE])
				stat_q[IRQ_WIDE] <= 1'b0;
			if (capt_ev & wctl_q.capt_mask)
				stat_q[IRQ_CAPT] <= 1'b1;
			else if (wr_to(IDX_IRQ_CLR) & wdat[IRQ_CAPT])
				stat_q[IRQ_CAPT] <= 1'b0;
			if (ntc & nmask_q)
				stat_q[IRQ_NARROW] <= 1'b1;
			else if (wr_to(IDX_IRQ_CLR) & wdat[IRQ_NARROW])
				stat_q[IRQ_NARROW] <= 1'b0;
		end
	end

	// output pins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= wctl_q.pin_sel ? wout_q : port_data_in;
		end
	end

	assign wide_timer_output_pin_out = pin_q;
	assign narrow_counter_output_out = nout_q;
	assign irq_out = |(stat_q & irq_en_q);

	// ==================================================================
	// checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	logic wctl_w;   // wide control written this edge
	assign wctl_w = wr_to(IDX_WIDE_CTL);

	AST_EN_WRITE: assert property (wctl_w |=>
		wen_q == $past(wdat[BIT_ENABLE])) else $error("enable bit");
	AST_MODN_RELOAD: assert property (wtc & ~demod & ~pp
		& ~wctl_q.single & ~wctl_w |=> wcnt_q == $past(wreload) && wen_q)
		else $error("modulo reload");
	AST_SINGLE_STOP: assert property (wtc & ~demod & wctl_q.single
		& ~wctl_w & ~(pp & ntc) |=> !wen_q) else $error("single stop");
	AST_EDGE_RELOAD: assert property (demod & wen_q & qual
		& ~wctl_q.single & ~wctl_w |=> wcnt_q == $past(wreload)
		&& capt_q == $past(wcnt_q)) else $error("edge capture");
	AST_EDGE_SKIP: assert property (demod & wen_q & wctl_q.single
		& ~arm_q & wtick & ~wctl_w & ~pp
		|=> wcnt_q == $past(wcnt_q) - 16'h0001) else $error("edge skip");
	AST_NARROW_CAPT: assert property (ncapt & wctl_q.capt_mask
		|=> capt_q == $past(wcnt_q) && stat_q[IRQ_CAPT])
		else $error("narrow capture");
	AST_ARM_ONCE: assert property (ehit & wctl_q.single & ~wctl_w
		|=> !arm_q) else $error("arm kept");
	AST_WRAP: assert property (demod & wtc & ~ehit & ~wctl_w
		|=> wcnt_q == 16'hFFFF && wtout_q) else $error("wrap");
	AST_TOUT_GATE: assert property (wtc & ~wctl_q.tout_mask
		& ~stat_q[IRQ_WIDE] |=> !stat_q[IRQ_WIDE]) else $error("mask");
	AST_PIN: assert property (wctl_q.pin_sel |=>
		pin_q == $past(wout_q)) else $error("pin source");
	AST_PP_TO_WIDE: assert property (pp & ntc & ~wctl_w
		& ~wr_to(IDX_NARROW_CTL) |=> wen_q && !nen_q
		&& wout_q == $past(shr_q.wide_init)
		&& wcnt_q == $past(wreload)) else $error("hand to wide");
	AST_PP_TO_NARROW: assert property (pp & wtc & ~wctl_w
		& ~wr_to(IDX_NARROW_CTL) |=> nen_q && !wen_q)
		else $error("hand to narrow");

	COV_PP: cover property (pp & ntc ##[1:600] pp & wtc);
	COV_ARM: cover property (arm_q ##[1:200] ehit);
	COV_WRAP: cover property (demod & wtc);
	COV_IRQ: cover property (irq_out);

endmodule

// file: tb/carrier_line_model.sv
// partner model: drives the carrier input line, counts changes on a pin
// assumes the bench calls burst right after a rising edge of clk_in
`timescale 1ns/1ps
module carrier_line_model (
	input  wire logic clk_in,
	input  wire logic pin_in,
	output logic      carrier_out,
	output int        toggles_out
);
	// ==================================================================
	// carrier line
	logic last_q;   // pin level seen at the previous edge

	// the carrier idles low between bursts, never floats
	initial begin
		carrier_out = 1'b0;
		toggles_out = 0;
		last_q = 1'b0;
	end

	// one burst: rising edge, high for len cycles, falling edge
	task automatic burst(input int len);
		@(posedge clk_in);
		carrier_out <= 1'b1;
		repeat (len) @(posedge clk_in);
		carrier_out <= 1'b0;
	endtask

	// ==================================================================
	// pin watcher: counts every level change of the timer output
	always @(posedge clk_in) begin
		if (pin_in !== last_q)
			toggles_out <= toggles_out + 1;
		last_q <= pin_in;
	end
endmodule

// file: tb/timer16_demod_pingpong_bench.sv
// bench for the timer block: register table, counting modes, ping-pong
// assumes the timer package and the carrier partner model compile first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end
module timer16_demod_pingpong_bench;
	import timer16_pkg::*;
	// ==================================================================
	// signals
	logic        clk_in            = 1'b0;
	logic        arst_n_in         = 1'b0;
	logic [3:0]  avs_address_in    = 4'h0;
	logic        avs_read_in       = 1'b0;
	logic        avs_write_in      = 1'b0;
	logic [31:0] avs_writedata_in  = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        carrier_in;
	logic        port_data_in      = 1'b0;
	logic        pin_out;
	logic        narrow_out;
	logic        irq_out;
	int          toggles;
	int          mismatches        = 0;
	int          n_tests           = 0;
	int          t0;
	logic [7:0]  rd;
	logic [15:0] cap;
	logic [15:0] cap_first;

	// register rows: index, write data, byte enables, expected read
	typedef struct packed {
		logic [3:0] idx;
		logic [7:0] wd;
		logic [3:0] be;
		logic [7:0] exp;
	} row_t;
	row_t rows [12] = '{
		'{IDX_WIDE_CTL, 8'h1E, 4'hF, 8'h1E},
		'{IDX_WIDE_CTL, 8'h20, 4'hF, 8'h00},
		'{IDX_WIDE_RH, 8'hA5, 4'hF, 8'hA5},
		'{IDX_WIDE_RH, 8'hFF, 4'h0, 8'hA5},
		'{IDX_WIDE_RL, 8'h5A, 4'hF, 8'h5A},
		'{IDX_PORT_CFG, 8'hFF, 4'hF, 8'h00},
		'{IDX_CAPT_H, 8'hFF, 4'hF, 8'h00},
		'{4'hF, 8'hFF, 4'hF, 8'h00},
		'{IDX_IRQ_EN, 8'h07, 4'hF, 8'h07},
		'{IDX_IRQ_EN, 8'h00, 4'hF, 8'h00},
		'{IDX_SHARED, 8'h30, 4'hF, 8'h30},
		'{IDX_SHARED, 8'h00, 4'hF, 8'h00}
	};

	// ==================================================================
	// clock, design and partner
	always #10 clk_in = ~clk_in;

	timer16_demod_pingpong i_timer16_demod_pingpong (
		.clk_in                    (clk_in),
		.arst_n_in                 (arst_n_in),
		.avs_address_in            (avs_address_in),
		.avs_read_in               (avs_read_in),
		.avs_write_in              (avs_write_in),
		.avs_writedata_in          (avs_writedata_in),
		.avs_byteenable_in         (avs_byteenable_in),
		.avs_readdata_out          (avs_readdata_out),
		.avs_waitrequest_out       (avs_waitrequest_out),
		.carrier_in                (carrier_in),
		.port_data_in              (port_data_in),
		.wide_timer_output_pin_out (pin_out),
		.narrow_counter_output_out (narrow_out),
		.irq_out                   (irq_out)
	);

	carrier_line_model i_carrier_line_model (
		.clk_in      (clk_in),
		.pin_in      (narrow_out),
		.carrier_out (carrier_in),
		.toggles_out (toggles)
	);

	// ==================================================================
	// tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one bus cycle: request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] idx,
		input logic [7:0] wd, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in    <= idx;
		avs_writedata_in  <= {24'h0, wd};
		avs_byteenable_in <= be;
		avs_write_in      <= wr;
		avs_read_in       <= ~wr;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 40);
		if (n >= 40) begin
			mismatches++;
			report_and_stop();
		end
		rd = avs_readdata_out[7:0];
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
	endtask

	task automatic wreg(input logic [3:0] idx, input logic [7:0] wd);
		bus(1'b1, idx, wd, 4'hF);
	endtask

	task automatic rreg(input logic [3:0] idx);
		bus(1'b0, idx, 8'h00, 4'hF);
	endtask

	// capture halves are read one after the other
	task automatic read_capt();
		rreg(IDX_CAPT_H);
		cap[15:8] = rd;
		rreg(IDX_CAPT_L);
		cap[7:0] = rd;
	endtask

	// ==================================================================
	// hang guard
	initial begin
		repeat (100000) @(posedge clk_in);
		mismatches++;
		report_and_stop();
	end

	// ==================================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rreg(IDX_WIDE_CTL);
		`CHK("ctl reset", CTL_RST, rd)
		`CHK("irq reset", 1'b0, irq_out)
		foreach (rows[i]) begin
			bus(1'b1, rows[i].idx, rows[i].wd, rows[i].be);
			rreg(rows[i].idx);
			`CHK("row", rows[i].exp, rd)
		end
		// pin source: port value, then idle timer output
		port_data_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		`CHK("pin port", 1'b1, pin_out)
		wreg(IDX_WIDE_CTL, 8'h01);
		repeat (3) @(posedge clk_in);
		`CHK("pin timer", 1'b0, pin_out)
		// single pass at each divider, reload 3 gives 4 ticks
		wreg(IDX_WIDE_RH, 8'h00);
		wreg(IDX_WIDE_RL, 8'h03);
		for (int d = 0; d < 4; d++) begin
			wreg(IDX_WIDE_CTL, 8'hC2 | (8'(d) << 3));
			if (d >= 2) begin
				repeat (4) @(posedge clk_in);
				rreg(IDX_WIDE_CTL);
				`CHK("running", 1'b1, rd[BIT_ENABLE])
			end
			repeat (40) @(posedge clk_in);
			rreg(IDX_WIDE_CTL);
			`CHK("single stop", 1'b0, rd[BIT_ENABLE])
			rreg(IDX_IRQ_STAT);
			`CHK("wide flag", 1'b1, rd[IRQ_WIDE])
			if (d < 3)
				wreg(IDX_IRQ_CLR, 8'h07);
		end
		// interrupt: masked, enabled, cleared
		`CHK("irq masked", 1'b0, irq_out)
		wreg(IDX_IRQ_EN, 8'h01);
		@(posedge clk_in);
		`CHK("irq on", 1'b1, irq_out)
		wreg(IDX_IRQ_CLR, 8'h01);
		@(posedge clk_in);
		`CHK("irq cleared", 1'b0, irq_out)
		// modulo keeps running with its timeout mask off, then stop
		wreg(IDX_WIDE_CTL, 8'h80);
		repeat (40) @(posedge clk_in);
		rreg(IDX_WIDE_CTL);
		`CHK("modulo run", 1'b1, rd[BIT_ENABLE])
		rreg(IDX_IRQ_STAT);
		`CHK("masked flag", 1'b0, rd[IRQ_WIDE])
		wreg(IDX_WIDE_CTL, 8'h00);
		rreg(IDX_WIDE_CTL);
		`CHK("stopped", 1'b0, rd[BIT_ENABLE])
		// demod, every rising edge recognized: second rise recaptures
		wreg(IDX_SHARED, 8'h40);
		wreg(IDX_WIDE_RH, 8'h10);
		wreg(IDX_WIDE_RL, 8'h00);
		wreg(IDX_WIDE_CTL, 8'h82);
		i_carrier_line_model.burst(4);
		repeat (300) @(posedge clk_in);
		i_carrier_line_model.burst(4);
		read_capt();
		`CHK("recapture", 8'h0E, cap[15:8])
		// wrap from zero sets the sticky timeout bit; start with it clear
		wreg(IDX_WIDE_CTL, 8'h20);
		rreg(IDX_WIDE_CTL);
		`CHK("flag cleared", 8'h00, rd)
		wreg(IDX_WIDE_RL, 8'h03);
		wreg(IDX_WIDE_RH, 8'h00);
		wreg(IDX_WIDE_CTL, 8'h82);
		repeat (20) @(posedge clk_in);
		rreg(IDX_WIDE_CTL);
		`CHK("timeout set", 8'hA2, rd)
		wreg(IDX_WIDE_CTL, 8'h82);
		rreg(IDX_WIDE_CTL);
		`CHK("write 0 kept", 8'hA2, rd)
		wreg(IDX_WIDE_CTL, 8'hA2);
		rreg(IDX_WIDE_CTL);
		`CHK("write 1 clr", 8'h82, rd)
		i_carrier_line_model.burst(2);
		read_capt();
		`CHK("wrapped", 8'hFF, cap[15:8])
		// ignore mode: armed edge captures, later edges skipped
		wreg(IDX_WIDE_CTL, 8'h00);
		wreg(IDX_WIDE_RH, 8'h10);
		wreg(IDX_WIDE_RL, 8'h00);
		wreg(IDX_IRQ_CLR, 8'h07);
		wreg(IDX_WIDE_CTL, 8'hC6);
		i_carrier_line_model.burst(4);
		read_capt();
		`CHK("armed edge", 8'h0F, cap[15:8])
		cap_first = cap;
		repeat (300) @(posedge clk_in);
		i_carrier_line_model.burst(4);
		read_capt();
		`CHK("edge skipped", cap_first, cap)
		wreg(IDX_IRQ_CLR, 8'h07);
		wreg(IDX_NARROW_RH, 8'h05);
		wreg(IDX_NARROW_RL, 8'h05);
		wreg(IDX_NARROW_CTL, 8'h80);
		repeat (30) @(posedge clk_in);
		read_capt();
		`CHK("narrow capture", 8'h0E, cap[15:8])
		rreg(IDX_IRQ_STAT);
		`CHK("capt flag", 1'b1, rd[IRQ_CAPT])
		// falling-edge select: the rise is ignored, the fall captures
		wreg(IDX_NARROW_CTL, 8'h00);
		wreg(IDX_SHARED, 8'h50);
		wreg(IDX_WIDE_CTL, 8'h00);
		wreg(IDX_WIDE_CTL, 8'h82);
		i_carrier_line_model.burst(300);
		read_capt();
		`CHK("fall edge", 8'h0E, cap[15:8])
		// stop both and clear flags before ping-pong
		wreg(IDX_NARROW_CTL, 8'h00);
		wreg(IDX_WIDE_CTL, 8'h00);
		wreg(IDX_IRQ_CLR, 8'h07);
		wreg(IDX_SHARED, 8'h06);
		wreg(IDX_NARROW_RH, 8'h03);
		wreg(IDX_NARROW_RL, 8'h03);
		wreg(IDX_WIDE_RL, 8'h04);
		wreg(IDX_WIDE_RH, 8'h00);
		wreg(IDX_WIDE_CTL, 8'h42);
		wreg(IDX_NARROW_CTL, 8'hC2);
		t0 = toggles;
		repeat (300) @(posedge clk_in);
		`CHK("pp repeats", 1'b1, (toggles - t0) >= 6)
		rreg(IDX_IRQ_STAT);
		`CHK("pp flags", 3'h5, rd[2:0] & 3'h5)
		wreg(IDX_SHARED, 8'h00);
		repeat (60) @(posedge clk_in);
		t0 = toggles;
		repeat (200) @(posedge clk_in);
		`CHK("pp ended", t0, toggles)
		rreg(IDX_NARROW_CTL);
		`CHK("narrow ctl", 8'h62, rd)
		// mid-run reset: running counter and set flags go back to zero
		wreg(IDX_WIDE_CTL, 8'h82);
		repeat (10) @(posedge clk_in);
		`CHK("irq before reset", 1'b1, irq_out)
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rreg(IDX_WIDE_CTL);
		`CHK("mid reset ctl", CTL_RST, rd)
		rreg(IDX_IRQ_STAT);
		`CHK("mid reset stat", 8'h00, rd)
		`CHK("mid reset irq", 1'b0, irq_out)
		report_and_stop();
	end
endmodule
